// ==== design/dsbc_map.svh ====
/*
 * Register map, field positions, reset values and timing figures for
 * the drive slot bypass control block.
 * Assumes byte addressing on an APB bus with 32-bit data.
 */
`ifndef DSBC_MAP_SVH
`define DSBC_MAP_SVH

// ============================================================
// Register byte addresses
`define DSBC_ADDR_W       8
`define DSBC_ADDR_SLOT    8'h24
`define DSBC_ADDR_STAT    8'h28
`define DSBC_ADDR_MASK    8'h2c
`define DSBC_ADDR_SRC     8'h30

// ============================================================
// Slot register fields
`define DSBC_BIT_EN       7
`define DSBC_BIT_IRQEN    6
`define DSBC_RES_HI       5
`define DSBC_RES_LO       2
`define DSBC_BIT_FB       1
`define DSBC_BIT_SD       0

// ============================================================
// Status and mask fields
`define DSBC_EV_W         2
`define DSBC_EV_SD        0
`define DSBC_EV_AUTO      1

// ============================================================
// Reset values
`define DSBC_RST_FB       1'b1
`define DSBC_RST_MASK     2'h3
`define DSBC_RST_SRC      8'h00

// ============================================================
// Timing
`define DSBC_CLK_NS       25
`define DSBC_LAT_NS       400
`define DSBC_LAT_CYC      (`DSBC_LAT_NS / `DSBC_CLK_NS)
`define DSBC_FILT_LEN     3
`define DSBC_SYNC_CYC     2

`endif

// ==== design/dsbc_pkg.sv ====
/*
 * Types shared by the drive slot bypass control modules.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package dsbc_pkg;
    typedef enum logic [1:0] {
        st_idle = 2'b01,
        st_hold = 2'b10
    } dsbc_apb_state_type;
endpackage : dsbc_pkg

`default_nettype wire

// ==== design/dsbc_in_filter.sv ====
/*
 * Two-stage synchroniser and glitch filter, one lane per input pin.
 * Assumes pins may change at any time relative to pclk.
 */
`default_nettype none

module dsbc_in_filter
    import dsbc_pkg::*;
#(
    parameter int WIDTH    = 2,
    parameter int FILT_LEN = 3
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Pins in, filtered levels out
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] filt_out
);
    localparam int CW = $clog2(FILT_LEN + 1);

    if (WIDTH < 1 || FILT_LEN < 1) begin : g_bad
        $error("dsbc_in_filter: WIDTH and FILT_LEN must be positive");
    end

    // ============================================================
    // Per-lane filter
    for (genvar i = 0; i < WIDTH; i++) begin : g_lane
        logic          s1_q;
        logic          s2_q;
        logic          out_q;
        logic          out_d;
        logic [CW-1:0] cnt_q;
        logic [CW-1:0] cnt_d;

        // A change is accepted only after FILT_LEN equal samples.
        always_comb begin
            out_d = out_q;
            cnt_d = '0;
            if (s2_q != out_q) begin
                if (cnt_q == CW'(FILT_LEN - 1)) begin
                    out_d = s2_q;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
        end

        // Pins power up pulled high, so the chain resets high.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                s1_q  <= 1'b1;
                s2_q  <= 1'b1;
                out_q <= 1'b1;
                cnt_q <= '0;
            end else begin
                s1_q  <= pin_in[i];
                s2_q  <= s1_q;
                out_q <= out_d;
                cnt_q <= cnt_d;
            end
        end

        assign filt_out[i] = out_q;
    end
endmodule : dsbc_in_filter

`default_nettype wire

// ==== design/dsbc_apb_slave.sv ====
/*
 * APB slave front end: one wait state, registered read data and error.
 * Assumes the register file supplies read data and a hit flag
 * combinationally from paddr.
 */
`default_nettype none

module dsbc_apb_slave
    import dsbc_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Register file side
    input  wire logic [31:0] rdata,
    input  wire logic        hit,
    output logic             wr_stb
);
    dsbc_apb_state_type state_q;
    dsbc_apb_state_type state_d;
    logic [31:0]        prdata_d;
    logic               pslverr_d;

    // ============================================================
    // Transfer sequencing
    // The wait state lets read data leave a flip-flop.
    always_comb begin
        state_d   = state_q;
        prdata_d  = prdata;
        pslverr_d = pslverr;
        case (state_q)
            st_idle: begin
                if (psel && penable) begin
                    state_d   = st_hold;
                    prdata_d  = pwrite ? 32'h0000_0000 : rdata;
                    pslverr_d = !hit;
                end
            end
            st_hold: begin
                state_d = st_idle;
            end
            default: begin
                state_d = st_idle;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= st_idle;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            state_q <= state_d;
            prdata  <= prdata_d;
            pslverr <= pslverr_d;
        end
    end

    assign pready = (state_q == st_hold);
    assign wr_stb = pready && psel && penable && pwrite && hit;
endmodule : dsbc_apb_slave

`default_nettype wire

// ==== design/dsbc_slot_bypass.sv ====
/*
 * Drive slot bypass control: slot register, pin logic for the force
 * bypass output and signal detect input, and the event interrupt.
 * Assumes one 40 MHz clock, an APB master, and pins that may change
 * at any time; the pad combines pin output and enable.
 */
// The register offsets and register access over APB were chosen for this implementation.
`default_nettype none
`include "dsbc_map.svh"

module dsbc_slot_bypass
    import dsbc_pkg::*;
#(
    parameter int FILT_LEN = `DSBC_FILT_LEN
) (
    // Clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // APB
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`DSBC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // Slot pins
    input  wire logic                    slot_bypass_pin_i,
    output logic                         slot_bypass_pin_o,
    output logic                         slot_bypass_pin_oe_n,
    input  wire logic                    slot_detect_pin_i,
    // Interrupt
    output logic                         irq_n
);
    // Pin path to cleared output must fit the loss-of-signal budget.
    if (FILT_LEN < 1 ||
        `DSBC_SYNC_CYC + FILT_LEN + 1 > `DSBC_LAT_CYC) begin : g_bad
        $error("dsbc_slot_bypass: FILT_LEN too large for latency");
    end

    // ============================================================
    // Pin filtering
    logic [1:0] filt;
    logic       sd_filt;
    logic       byp_filt;

    dsbc_in_filter #(
        .WIDTH    (2),
        .FILT_LEN (FILT_LEN)
    ) u_filter (
        .pclk     (pclk),
        .presetn  (presetn),
        .pin_in   ({slot_bypass_pin_i, slot_detect_pin_i}),
        .filt_out (filt)
    );

    assign sd_filt  = filt[0];
    assign byp_filt = filt[1];

    // ============================================================
    // Bus front end
    logic [31:0] rdata;
    logic        hit;
    logic        wr_stb;

    dsbc_apb_slave u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .pready  (pready),
        .prdata  (prdata),
        .pslverr (pslverr),
        .rdata   (rdata),
        .hit     (hit),
        .wr_stb  (wr_stb)
    );

    logic wr_slot;
    logic wr_stat;
    logic wr_mask;

    assign wr_slot = wr_stb && (paddr == `DSBC_ADDR_SLOT);
    assign wr_stat = wr_stb && (paddr == `DSBC_ADDR_STAT);
    assign wr_mask = wr_stb && (paddr == `DSBC_ADDR_MASK);

    // ============================================================
    // Slot register
    logic en_q;
    logic en_d;
    logic irq_en_q;
    logic irq_en_d;
    logic fb_q;
    logic fb_d;

    // The hardware clear is applied after the write so that a write
    // cannot re-arm normal mode while the signal is lost and enable is already set.
    always_comb begin
        en_d     = en_q;
        irq_en_d = irq_en_q;
        fb_d     = fb_q;
        if (wr_slot) begin
            // Detect and reserved bits are not stored at all.
            en_d     = pwdata[`DSBC_BIT_EN];
            irq_en_d = pwdata[`DSBC_BIT_IRQEN];
            fb_d     = pwdata[`DSBC_BIT_FB];
        end
        if (en_q && !sd_filt) begin
            fb_d = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q     <= 1'b0;
            irq_en_q <= 1'b0;
            fb_q     <= `DSBC_RST_FB;
        end else begin
            en_q     <= en_d;
            irq_en_q <= irq_en_d;
            fb_q     <= fb_d;
        end
    end

    // ============================================================
    // Pin drive
    // High on the pin leaves the external bypass inactive, low forces
    // bypass. With enable clear the pin is released to its pull-up.
    assign slot_bypass_pin_o    = en_q & fb_q;
    assign slot_bypass_pin_oe_n = !en_q;

    // ============================================================
    // Events and interrupt
    logic                  sd_prev_q;
    logic                  sd_edge;
    logic                  ev_sd;
    logic                  ev_auto;
    logic [`DSBC_EV_W-1:0] events;
    logic [`DSBC_EV_W-1:0] stat_q;
    logic [`DSBC_EV_W-1:0] stat_d;
    logic [`DSBC_EV_W-1:0] mask_q;
    logic [`DSBC_EV_W-1:0] mask_d;
    logic [7:0]            src_q;
    logic [7:0]            src_d;

    // The edge detector resets to the filter's reset level, so a reset
    // release never shows a false detect edge.
    assign sd_edge = sd_filt ^ sd_prev_q;
    assign ev_sd   = en_q && irq_en_q && sd_edge;
    // A loss of signal with the interrupt enable clear must stay silent,
    // so the hardware clear reports only under that enable as well.
    assign ev_auto = en_q && irq_en_q && !sd_filt && fb_q;

    always_comb begin
        events               = '0;
        events[`DSBC_EV_SD]   = ev_sd;
        events[`DSBC_EV_AUTO] = ev_auto;
        stat_d = stat_q;
        if (wr_stat) begin
            stat_d = stat_d & ~pwdata[`DSBC_EV_W-1:0];
        end
        // A new event wins over a clear in the same cycle.
        stat_d = stat_d | events;
        mask_d = wr_mask ? pwdata[`DSBC_EV_W-1:0] : mask_q;
        src_d  = ev_sd ? `DSBC_ADDR_SLOT : src_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sd_prev_q <= 1'b1;
            stat_q    <= '0;
            mask_q    <= `DSBC_RST_MASK;
            src_q     <= `DSBC_RST_SRC;
        end else begin
            sd_prev_q <= sd_filt;
            stat_q    <= stat_d;
            mask_q    <= mask_d;
            src_q     <= src_d;
        end
    end

    assign irq_n = ~|(stat_q & mask_q);

    // ============================================================
    // Read data
    logic [7:0] slot_rd;

    always_comb begin
        slot_rd                                = 8'h00;
        slot_rd[`DSBC_BIT_EN]                  = en_q;
        slot_rd[`DSBC_BIT_IRQEN]               = irq_en_q;
        // Before enabling, software learns the strapped default here.
        slot_rd[`DSBC_BIT_FB] = en_q ? fb_q : byp_filt;
        slot_rd[`DSBC_BIT_SD] = sd_filt;
        rdata = 32'h0000_0000;
        hit   = 1'b1;
        case (paddr)
            `DSBC_ADDR_SLOT: rdata[7:0]            = slot_rd;
            `DSBC_ADDR_STAT: rdata[`DSBC_EV_W-1:0] = stat_q;
            `DSBC_ADDR_MASK: rdata[`DSBC_EV_W-1:0] = mask_q;
            `DSBC_ADDR_SRC:  rdata[7:0]            = src_q;
            default:         hit                   = 1'b0;
        endcase
    end

    // ============================================================
    // Assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_pin_drives_fb: assert property (
        en_q |-> (!slot_bypass_pin_oe_n && slot_bypass_pin_o == fb_q)
    ) else $error("bypass pin does not follow force bypass");

    a_pins_released: assert property (
        !en_q |-> (slot_bypass_pin_oe_n && !slot_bypass_pin_o)
    ) else $error("bypass pin driven while disabled");

    a_loss_clears_fb: assert property (
        (en_q && !sd_filt) |=> !fb_q
    ) else $error("force bypass not cleared on loss");

    // Seven pin samples cover both sync stages, the filter and the
    // clear, which sits well inside the loss-of-signal budget.
    a_loss_latency: assert property (
        (en_q && !slot_detect_pin_i)[*7] |=> !slot_bypass_pin_o
    ) else $error("bypass pin late after loss of signal");

    a_auto_event: assert property (
        (en_q && irq_en_q && !sd_filt && fb_q) |=>
            stat_q[`DSBC_EV_AUTO]
    ) else $error("hardware clear did not raise its event");

    a_edge_raises_irq: assert property (
        (en_q && irq_en_q && sd_filt != $past(sd_filt)) |=>
            (stat_q[`DSBC_EV_SD] && src_q == `DSBC_ADDR_SLOT)
    ) else $error("detect edge did not raise interrupt");

    a_src_loads_slot: assert property (
        $changed(src_q) |-> (src_q == `DSBC_ADDR_SLOT && $past(ev_sd))
    ) else $error("source register changed without an event");

    a_irq_pin_low: assert property (
        (stat_q[`DSBC_EV_SD] && mask_q[`DSBC_EV_SD]) |-> !irq_n
    ) else $error("interrupt pin not asserted");

    a_no_irq_disabled: assert property (
        !(en_q && irq_en_q) |=>
            ($stable(src_q) && !$rose(stat_q[`DSBC_EV_SD]))
    ) else $error("interrupt raised while disabled");

    a_no_auto_disabled: assert property (
        !(en_q && irq_en_q) |=> !$rose(stat_q[`DSBC_EV_AUTO])
    ) else $error("hardware clear event raised while disabled");

    a_write_applies: assert property (
        (wr_slot && en_q && sd_filt) |=>
            (fb_q == $past(pwdata[`DSBC_BIT_FB]))
    ) else $error("force bypass write not applied");

    a_en_follows_write: assert property (
        wr_slot |=> (en_q == $past(pwdata[`DSBC_BIT_EN]))
    ) else $error("enable bit write not applied");

    a_sd_read: assert property (
        (pready && !pwrite && paddr == `DSBC_ADDR_SLOT) |->
            (prdata[`DSBC_BIT_SD] == $past(sd_filt) &&
             prdata[`DSBC_RES_HI:`DSBC_RES_LO] == 4'h0)
    ) else $error("slot read returns wrong detect or reserved");

    a_fb_read_pin: assert property (
        (pready && !pwrite && paddr == `DSBC_ADDR_SLOT && !$past(en_q))
            |-> (prdata[`DSBC_BIT_FB] == $past(byp_filt))
    ) else $error("disabled slot read misses the bypass pin level");

    c_irq_taken:   cover property (ev_sd ##1 !irq_n);
    c_auto_clear:  cover property (en_q && fb_q ##1 !fb_q);
    c_bypass_norm: cover property (wr_slot && en_q ##1 slot_bypass_pin_o);
    c_irq_release: cover property (!irq_n ##1 irq_n);
    c_bypass_low:  cover property (wr_slot && en_q && !pwdata[`DSBC_BIT_FB]);
endmodule : dsbc_slot_bypass

`default_nettype wire

// ==== test/dsbc_bru_model.sv ====
/*
 * Behavioural model of the external bypass, clock recovery and signal
 * detect unit that sits on the far side of one drive slot.
 * Assumes the bench sets the line resistor and the signal presence.
 */
`default_nettype none

module dsbc_bru_model (
    // Bench controls
    input  wire logic pull_hi,
    input  wire logic sig_ok,
    // Device pins
    input  wire logic pin_o,
    input  wire logic pin_oe_n,
    output logic      detect_o,
    output logic      bypass_lvl,
    output logic      bypass_on
);
    timeunit 1ns;
    timeprecision 1ps;

    // ============================================================
    // Pin levels
    // A released line rests at its resistor, never at the last value.
    assign bypass_lvl = pin_oe_n ? pull_hi : pin_o;
    // The force bypass input is active low: high keeps normal mode.
    assign bypass_on  = ~bypass_lvl;
    assign detect_o   = sig_ok;
endmodule : dsbc_bru_model

`default_nettype wire

// ==== test/tb.sv ====
/*
 * Self-checking bench for the drive slot bypass control block.
 * Assumes the design files and the far-side model are compiled first.
 */
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
    mismatches++; $display("wrong value at %0t: got %h expected %h", \
    $time, a, b); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ============================================================
    // Signals
    logic        pclk = 1'b0;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pin_o;
    logic        oe_n;
    logic        irq_n;
    logic        detect;
    logic        byp_lvl;
    logic        byp_on;
    logic        pull_hi;
    logic        sig_ok;
    logic [31:0] rd_d;
    logic        last_err;
    logic        irq_a;
    int          mismatches  = 0;
    int          comparisons = 0;

    always #12.5ns pclk = ~pclk;

    dsbc_slot_bypass u_dsbc_slot_bypass (
        .pclk                 (pclk),
        .presetn              (presetn),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .paddr                (paddr),
        .pwdata               (pwdata),
        .prdata               (prdata),
        .pready               (pready),
        .pslverr              (pslverr),
        .slot_bypass_pin_i    (byp_lvl),
        .slot_bypass_pin_o    (pin_o),
        .slot_bypass_pin_oe_n (oe_n),
        .slot_detect_pin_i    (detect),
        .irq_n                (irq_n)
    );

    dsbc_bru_model u_dsbc_bru_model (
        .pull_hi    (pull_hi),
        .sig_ok     (sig_ok),
        .pin_o      (pin_o),
        .pin_oe_n   (oe_n),
        .detect_o   (detect),
        .bypass_lvl (byp_lvl),
        .bypass_on  (byp_on)
    );

    // ============================================================
    // Tasks
    task automatic stop_test();
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic cycles(input int n);
        repeat (n) @(posedge pclk);
    endtask : cycles

    // One APB transfer; an edge passes first so psel is never set twice.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int   n;
        logic ok;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
            ok = (pready === 1'b1);
        end while (!ok && n < 20);
        rd_d     = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (!ok) begin
            mismatches++;
            stop_test();
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d});
    endtask : wr

    task automatic chk(input logic [7:0] a, input logic [31:0] exp,
                       input logic exp_err);
        apb(1'b0, a, 32'h00000000);
        `CHK(rd_d, exp)
        `CHK(last_err, exp_err)
    endtask : chk

    // The bypass output must fall within 16 cycles, that is 400 ns.
    task automatic wait_bypass();
        int n;
        n = 0;
        while (pin_o !== 1'b0 && n < 16) begin
            @(posedge pclk);
            n++;
        end
        `CHK(pin_o, 1'b0)
        if (pin_o !== 1'b0) begin
            stop_test();
        end
    endtask : wait_bypass

    // ============================================================
    // Sequence
    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h00000000;
        pull_hi = 1'b1;
        sig_ok  = 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        cycles(8);
        `CHK(oe_n, 1'b1)
        chk(8'h24, 32'h03, 1'b0);
        chk(8'h30, 32'h00, 1'b0);
        chk(8'h3c, 32'h00, 1'b1);
        // Disabled slot with a pulled-down line: no events, pins alone.
        pull_hi <= 1'b0;
        wr(8'h24, 8'h42);
        sig_ok  <= 1'b0;
        cycles(10);
        `CHK(oe_n, 1'b1)
        chk(8'h24, 32'h40, 1'b0);
        chk(8'h28, 32'h00, 1'b0);
        pull_hi <= 1'b1;
        sig_ok  <= 1'b1;
        cycles(10);
        // Enable with reserved and detect bits written as ones and zero.
        wr(8'h24, 8'hbe);
        cycles(2);
        `CHK({oe_n, pin_o}, 2'b01)
        `CHK(byp_on, 1'b0)
        chk(8'h24, 32'h83, 1'b0);
        wr(8'h24, 8'h81);
        cycles(2);
        `CHK(byp_on, 1'b1)
        wr(8'h24, 8'h83);
        cycles(2);
        `CHK(pin_o, 1'b1)
        // Loss of signal with the interrupt enable clear.
        sig_ok <= 1'b0;
        wait_bypass();
        cycles(4);
        `CHK(irq_n, 1'b1)
        chk(8'h24, 32'h80, 1'b0);
        chk(8'h28, 32'h00, 1'b0);
        chk(8'h30, 32'h00, 1'b0);
        wr(8'h28, 8'h03);
        sig_ok <= 1'b1;
        cycles(10);
        chk(8'h28, 32'h00, 1'b0);
        // Loss of signal with the interrupt enable set.
        wr(8'h24, 8'hc3);
        sig_ok <= 1'b0;
        wait_bypass();
        cycles(4);
        chk(8'h28, 32'h03, 1'b0);
        chk(8'h30, 32'h24, 1'b0);
        wr(8'h2c, 8'h00);
        cycles(2);
        irq_a = irq_n;
        wr(8'h2c, 8'h03);
        cycles(2);
        `CHK(irq_a ^ irq_n, 1'b1)
        `CHK({irq_a, irq_n}, 2'b10)
        // Setting force bypass while the signal is lost must not stick.
        wr(8'h24, 8'hc3);
        cycles(2);
        `CHK(pin_o, 1'b0)
        wr(8'h28, 8'h03);
        chk(8'h28, 32'h00, 1'b0);
        sig_ok <= 1'b1;
        cycles(10);
        chk(8'h28, 32'h01, 1'b0);
        // A reset in mid-run returns pins, interrupt and registers.
        presetn <= 1'b0;
        cycles(3);
        `CHK({oe_n, pin_o, irq_n}, 3'b101)
        presetn <= 1'b1;
        chk(8'h24, 32'h03, 1'b0);
        chk(8'h28, 32'h00, 1'b0);
        chk(8'h30, 32'h00, 1'b0);
        stop_test();
    end
endmodule : tb

`default_nettype wire
